// file: verilog/cpu_regs_pkg.sv
/*
  Shared constants and types of the processor register set: bus register
  indices, status word layout, reset values, vector offsets and operand sizes.
  Assumes nothing; imported by every module of the register set.
*/
package cpu_regs_pkg;
  localparam int XLEN = 32;
  localparam int NGPR = 16;
  localparam int IDX_REG = 0;
  localparam int STK_REG = 15;
  // Status word layout
  localparam int SR_T_BIT = 0;
  localparam int SR_S_BIT = 1;
  localparam int SR_IMASK_LSB = 4;
  localparam int SR_IMASK_MSB = 7;
  localparam int SR_Q_BIT = 8;
  localparam int SR_M_BIT = 9;
  localparam logic [31:0] SR_USED_MASK = 32'h0000_03f3;
  localparam logic [31:0] SR_RESET = 32'h0000_00f0;
  localparam logic [3:0] IMASK_RESET = 4'hf;
  localparam logic [31:0] VBR_RESET = 32'h0000_0000;
  localparam logic [31:0] UNDEF_RESET = 32'h0000_0000;
  // Vector table entries, relative to the vector base
  localparam logic [31:0] VEC_PC_OFS = 32'h0000_0000;
  localparam logic [31:0] VEC_SP_OFS = 32'h0000_0004;
  // Sizes and steps
  localparam logic [31:0] INSTR_BYTES = 32'h0000_0002;
  localparam logic [31:0] LONG_BYTES = 32'h0000_0004;
  localparam int MAC_W = 42;
  localparam int MUL_W = 16;
  localparam int IMM_W = 8;
  // Instruction rate: one basic instruction per clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int REF_INSTR_NS = 50;
  localparam int REF_CLK_MHZ = 20;
  localparam int INSTR_CYCLES = (REF_INSTR_NS * REF_CLK_MHZ + 999) / 1000;
  // Avalon word indices; byte address is four times the index
  localparam int AV_ADDR_W = 5;
  localparam logic [4:0] A_GPR0 = 5'h00;
  localparam logic [4:0] A_SR = 5'h10;
  localparam logic [4:0] A_GBR = 5'h11;
  localparam logic [4:0] A_VBR = 5'h12;
  localparam logic [4:0] A_MULTIPLY_ACC_HIGH = 5'h13;
  localparam logic [4:0] A_MULTIPLY_ACC_LOW = 5'h14;
  localparam logic [4:0] A_PR = 5'h15;
  localparam logic [4:0] A_PC = 5'h16;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_e;
  typedef enum logic {IMM_SIGNED, IMM_ZERO} imm_e;
endpackage

// file: verilog/operand_extend.sv
/*
  Widens memory operands and 8-bit immediates to 32-bit register values.
  Purely combinational; the caller decides which result is written.
*/
`timescale 1ns/100ps
module operand_extend
  import cpu_regs_pkg::*;
(
  // Memory load operand
  input wire logic [31:0] mem_data,
  input wire cpu_regs_pkg::size_e mem_size,
  output logic [31:0] mem_ext,
  // Immediate field
  input wire logic [7:0] imm8,
  input wire cpu_regs_pkg::imm_e imm_kind,
  output logic [31:0] imm_ext
);
  wire [31:0] byte_sx = {{24{mem_data[7]}}, mem_data[7:0]};
  wire [31:0] word_sx = {{16{mem_data[15]}}, mem_data[15:0]};
  // Narrow loads always sign-extend
  assign mem_ext = (mem_size == SZ_BYTE) ? byte_sx :
                   (mem_size == SZ_WORD) ? word_sx : mem_data;
  // Arithmetic sign-extends, logic zero-extends
  assign imm_ext = (imm_kind == IMM_ZERO) ? {24'h00_0000, imm8} : {{24{imm8[7]}}, imm8};
endmodule

// file: verilog/align_check.sv
/*
  Address error detection for byte, word and longword accesses.
  Combinational; the memory access unit samples the result with the request.
*/
`timescale 1ns/100ps
module align_check
  import cpu_regs_pkg::*;
(
  input wire logic [31:0] addr,
  input wire cpu_regs_pkg::size_e size,
  output logic addr_err
);
  // Bytes anywhere, words on 2n, longwords on 4n
  assign addr_err = (size == SZ_WORD) ? addr[0] :
                    (size == SZ_LONG) ? (addr[1:0] != 2'h0) : 1'b0;
endmodule

// file: verilog/cpu_register_set.sv
/*
  Architectural register set of the processor core: general, control and
  system registers, reset vector fetch, stack pointer stepping, multiply
  accumulate, operand widening, alignment checks and an Avalon-MM view.
  Assumes the pipeline and memory unit are synchronous to CLOCK and that
  the vector table read port answers with VEC_VALID.
*/
`timescale 1ns/100ps
module cpu_register_set
  import cpu_regs_pkg::*;
#(
  parameter int unsigned MAC_BITS = cpu_regs_pkg::MAC_W
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // Avalon-MM slave
  input wire logic [cpu_regs_pkg::AV_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Reset vector fetch
  output logic VEC_RD,
  output logic [31:0] VEC_ADDR,
  input wire logic VEC_VALID,
  input wire logic [31:0] VEC_RDATA,
  output logic CORE_READY,
  // Operand reads
  input wire logic [3:0] RD_A_SEL,
  output logic [31:0] RD_A_DATA,
  input wire logic [3:0] RD_B_SEL,
  output logic [31:0] RD_B_DATA,
  output logic [31:0] INDEX_GENERAL_REG,
  output logic [31:0] STACK_POINTER,
  // General register write
  input wire logic WR_EN,
  input wire logic [3:0] WR_SEL,
  input wire logic WR_FROM_MEM,
  input wire logic WR_FROM_IMM,
  input wire logic [31:0] WR_DATA,
  input wire cpu_regs_pkg::size_e WR_SIZE,
  input wire logic [7:0] IMM_FIELD,
  input wire cpu_regs_pkg::imm_e IMM_KIND,
  input wire logic IDX_WR_EN,
  input wire logic [31:0] IDX_WR_DATA,
  // Exception stacking
  input wire logic SP_PUSH,
  input wire logic SP_POP,
  output logic [31:0] STACK_ADDR,
  output logic STACK_ADDR_ERR,
  // Control and system registers
  input wire logic STATUS_WR_EN,
  input wire logic GBR_WR_EN,
  input wire logic VBR_WR_EN,
  input wire logic PR_WR_EN,
  input wire logic [31:0] CTRL_WR_DATA,
  input wire logic T_WR_EN,
  input wire logic T_VALUE,
  output logic [31:0] STATUS_WORD,
  output logic T_FLAG,
  output logic [3:0] INTERRUPT_MASK_FIELD,
  output logic [31:0] GLOBAL_BASE_REG,
  output logic [31:0] VECTOR_BASE_REG,
  output logic [31:0] RETURN_LINK_REG,
  output logic [31:0] PERIPH_ADDR,
  input wire logic [7:0] GBR_DISP,
  // Program counter
  input wire logic INSTR_ADV,
  input wire logic PC_LOAD,
  input wire logic [31:0] PC_TARGET,
  output logic [31:0] PROGRAM_COUNTER,
  input wire logic [7:0] PCREL_DISP,
  input wire logic PCREL_LONG,
  output logic [31:0] PCREL_ADDR,
  // Multiply unit
  input wire logic MUL_EN,
  input wire logic MAC_EN,
  input wire logic [15:0] MUL_A,
  input wire logic [15:0] MUL_B,
  output logic [31:0] MULTIPLY_ACC_HIGH,
  output logic [31:0] MULTIPLY_ACC_LOW,
  // Memory operand alignment
  input wire logic [31:0] MEM_ADDR,
  input wire cpu_regs_pkg::size_e MEM_SIZE,
  output logic MEM_ADDR_ERR
);
  import cpu_regs_pkg::*;

  if (MAC_BITS <= XLEN || MAC_BITS > 2 * XLEN) begin : g_bad_mac
    $error("MAC_BITS must lie between 33 and 64");
  end

  typedef enum logic [1:0] {VF_PC, VF_SP, VF_RUN} vfetch_e;
  vfetch_e state_ff;
  vfetch_e nxt_state;

  // Register storage
  logic [31:0] gpr_ff [NGPR];
  logic [31:0] nxt_gpr [NGPR];
  logic [31:0] sr_ff, gbr_ff, vbr_ff, multiply_acc_high_ff, multiply_acc_low_ff, pr_ff, pc_ff;
  logic [31:0] nxt_sr, nxt_gbr, nxt_vbr, nxt_multiply_acc_high, nxt_multiply_acc_low, nxt_pr, nxt_pc;

  wire running = (state_ff == VF_RUN);
  wire pc_take = (state_ff == VF_PC) && VEC_VALID;
  wire sp_take = (state_ff == VF_SP) && VEC_VALID;

  // Vector fetch sequence after reset
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      VF_PC: if (VEC_VALID) nxt_state = VF_SP;
      VF_SP: if (VEC_VALID) nxt_state = VF_RUN;
      VF_RUN: nxt_state = VF_RUN;
      default: nxt_state = VF_PC;
    endcase
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) state_ff <= VF_PC;
    else state_ff <= nxt_state;
  end
  assign VEC_RD = !running;
  assign VEC_ADDR = vbr_ff + ((state_ff == VF_SP) ? VEC_SP_OFS : VEC_PC_OFS);
  assign CORE_READY = running;

  // Bus access: pipeline writes have priority, so the bus waits for a quiet cycle
  wire pipe_busy = WR_EN || IDX_WR_EN || SP_PUSH || SP_POP || STATUS_WR_EN ||
                   GBR_WR_EN || VBR_WR_EN || PR_WR_EN || T_WR_EN || MUL_EN || MAC_EN ||
                   INSTR_ADV || PC_LOAD;
  wire bus_req = AVS_READ || AVS_WRITE;
  wire bus_go = bus_req && running && !pipe_busy;
  wire bus_wr = AVS_WRITE && bus_go;
  wire gpr_area = (AVS_ADDRESS < 5'(NGPR));
  wire [3:0] bus_idx = AVS_ADDRESS[3:0];
  assign AVS_WAITREQUEST = bus_req && !bus_go;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // Combinational read of current contents, taken once waitrequest drops; unmapped words read zero
  assign AVS_READDATA = gpr_area ? gpr_ff[bus_idx] :
                        (AVS_ADDRESS == A_SR) ? sr_ff :
                        (AVS_ADDRESS == A_GBR) ? gbr_ff :
                        (AVS_ADDRESS == A_VBR) ? vbr_ff :
                        (AVS_ADDRESS == A_MULTIPLY_ACC_HIGH) ? multiply_acc_high_ff :
                        (AVS_ADDRESS == A_MULTIPLY_ACC_LOW) ? multiply_acc_low_ff :
                        (AVS_ADDRESS == A_PR) ? pr_ff :
                        (AVS_ADDRESS == A_PC) ? pc_ff : 32'h0000_0000;

  // Operand widening and alignment
  logic [31:0] mem_ext, imm_ext;
  operand_extend u_ext (
    .mem_data(WR_DATA),
    .mem_size(WR_SIZE),
    .mem_ext(mem_ext),
    .imm8(IMM_FIELD),
    .imm_kind(IMM_KIND),
    .imm_ext(imm_ext)
  );
  align_check u_align (
    .addr(MEM_ADDR),
    .size(MEM_SIZE),
    .addr_err(MEM_ADDR_ERR)
  );

  wire [31:0] wr_value = WR_FROM_IMM ? imm_ext : (WR_FROM_MEM ? mem_ext : WR_DATA);
  wire [31:0] sp_now = gpr_ff[STK_REG];
  wire [31:0] sp_adj = SP_PUSH ? (sp_now - LONG_BYTES) : (sp_now + LONG_BYTES);

  // Stack slots are longwords only; a misaligned pointer is flagged
  assign STACK_ADDR = SP_PUSH ? sp_adj : sp_now;
  assign STACK_ADDR_ERR = (SP_PUSH || SP_POP) && (sp_now[1:0] != 2'h0);

  genvar g;
  for (g = 0; g < NGPR; g++) begin : g_gpr
    wire bus_hit = bus_wr && gpr_area && (bus_idx == 4'(g));
    wire pipe_hit = WR_EN && (WR_SEL == 4'(g));
    wire idx_hit = (g == IDX_REG) && IDX_WR_EN;
    wire stk_hit = (g == STK_REG) && (SP_PUSH || SP_POP);
    wire vec_hit = (g == STK_REG) && sp_take;
    assign nxt_gpr[g] = vec_hit ? VEC_RDATA :
                        bus_hit ? merge(gpr_ff[g], AVS_WRITEDATA, AVS_BYTEENABLE) :
                        idx_hit ? IDX_WR_DATA :
                        pipe_hit ? wr_value :
                        stk_hit ? sp_adj : gpr_ff[g];
    always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) gpr_ff[g] <= UNDEF_RESET;
      else gpr_ff[g] <= nxt_gpr[g];
    end
  end

  assign RD_A_DATA = gpr_ff[RD_A_SEL];
  assign RD_B_DATA = gpr_ff[RD_B_SEL];
  assign INDEX_GENERAL_REG = gpr_ff[IDX_REG];
  assign STACK_POINTER = sp_now;

  // Control registers; reserved status bits never take a one
  wire bus_sr = bus_wr && (AVS_ADDRESS == A_SR);
  wire [31:0] sr_wr = bus_sr ? merge(sr_ff, AVS_WRITEDATA, AVS_BYTEENABLE) : CTRL_WR_DATA;
  logic [31:0] sr_mid;
  always_comb begin
    sr_mid = (bus_sr || STATUS_WR_EN) ? (sr_wr & SR_USED_MASK) : sr_ff;
    if (T_WR_EN && !bus_sr) sr_mid[SR_T_BIT] = T_VALUE;
    nxt_sr = sr_mid;
  end
  assign nxt_gbr = (bus_wr && AVS_ADDRESS == A_GBR) ? merge(gbr_ff, AVS_WRITEDATA, AVS_BYTEENABLE) :
                   GBR_WR_EN ? CTRL_WR_DATA : gbr_ff;
  assign nxt_vbr = (bus_wr && AVS_ADDRESS == A_VBR) ? merge(vbr_ff, AVS_WRITEDATA, AVS_BYTEENABLE) :
                   VBR_WR_EN ? CTRL_WR_DATA : vbr_ff;
  assign nxt_pr = (bus_wr && AVS_ADDRESS == A_PR) ? merge(pr_ff, AVS_WRITEDATA, AVS_BYTEENABLE) :
                  PR_WR_EN ? CTRL_WR_DATA : pr_ff;

  // One 16-bit instruction per clock; reset clears it, then the vector fetch loads the entry
  assign nxt_pc = pc_take ? VEC_RDATA :
                  (bus_wr && AVS_ADDRESS == A_PC) ? merge(pc_ff, AVS_WRITEDATA, AVS_BYTEENABLE) :
                  PC_LOAD ? PC_TARGET :
                  (INSTR_ADV && running) ? pc_ff + INSTR_BYTES : pc_ff;

  // Wide immediates live in a table behind the program counter
  wire [31:0] pcrel_base = PCREL_LONG ? (pc_ff & ~(LONG_BYTES - 32'h1)) : pc_ff;
  wire [31:0] pcrel_ofs = PCREL_LONG ? {22'h0, PCREL_DISP, 2'h0} : {23'h0, PCREL_DISP, 1'h0};
  assign PCREL_ADDR = pcrel_base + LONG_BYTES + pcrel_ofs;
  // Peripheral window off the global base, byte displacement
  assign PERIPH_ADDR = gbr_ff + {24'h00_0000, GBR_DISP};

  // Signed multiply; accumulate keeps MAC_BITS, high word sign-extended
  wire signed [31:0] product = $signed(MUL_A) * $signed(MUL_B);
  wire [MAC_BITS-1:0] acc_now = {multiply_acc_high_ff[MAC_BITS-XLEN-1:0], multiply_acc_low_ff};
  wire [MAC_BITS-1:0] acc_sum = acc_now + MAC_BITS'(product);
  wire [31:0] acc_hi = XLEN'($signed(acc_sum[MAC_BITS-1:XLEN]));
  assign nxt_multiply_acc_low = MAC_EN ? acc_sum[XLEN-1:0] : MUL_EN ? product :
                    (bus_wr && AVS_ADDRESS == A_MULTIPLY_ACC_LOW) ? AVS_WRITEDATA : multiply_acc_low_ff;
  assign nxt_multiply_acc_high = MAC_EN ? acc_hi :
                    (bus_wr && AVS_ADDRESS == A_MULTIPLY_ACC_HIGH) ? AVS_WRITEDATA : multiply_acc_high_ff;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      sr_ff <= SR_RESET;
      vbr_ff <= VBR_RESET;
      gbr_ff <= UNDEF_RESET;
      multiply_acc_high_ff <= UNDEF_RESET;
      multiply_acc_low_ff <= UNDEF_RESET;
      pr_ff <= UNDEF_RESET;
      pc_ff <= UNDEF_RESET;
    end else begin
      sr_ff <= nxt_sr;
      vbr_ff <= nxt_vbr;
      gbr_ff <= nxt_gbr;
      multiply_acc_high_ff <= nxt_multiply_acc_high;
      multiply_acc_low_ff <= nxt_multiply_acc_low;
      pr_ff <= nxt_pr;
      pc_ff <= nxt_pc;
    end
  end

  assign STATUS_WORD = sr_ff;
  assign T_FLAG = sr_ff[SR_T_BIT];
  assign INTERRUPT_MASK_FIELD = sr_ff[SR_IMASK_MSB:SR_IMASK_LSB];
  assign GLOBAL_BASE_REG = gbr_ff;
  assign VECTOR_BASE_REG = vbr_ff;
  assign RETURN_LINK_REG = pr_ff;
  assign PROGRAM_COUNTER = pc_ff;
  assign MULTIPLY_ACC_HIGH = multiply_acc_high_ff;
  assign MULTIPLY_ACC_LOW = multiply_acc_low_ff;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  sequence s_pc_entry;
    (state_ff == VF_PC) && VEC_VALID;
  endsequence
  sequence s_sp_entry;
    (state_ff == VF_SP) && VEC_VALID;
  endsequence

  property p_sr_reset;
    $rose(RSTN) |-> (sr_ff[SR_IMASK_MSB:SR_IMASK_LSB] == IMASK_RESET) && ((sr_ff & ~SR_USED_MASK) == 32'h0);
  endproperty
  a_sr_reset: assert property (p_sr_reset) else $error("status word reset value wrong");

  property p_vbr_reset;
    $rose(RSTN) |-> (vbr_ff == VBR_RESET) && (VEC_ADDR == VEC_PC_OFS);
  endproperty
  a_vbr_reset: assert property (p_vbr_reset) else $error("vector base not zero after reset");

  property p_vec_done;
    s_sp_entry |=> CORE_READY && !VEC_RD;
  endproperty
  a_vec_done: assert property (p_vec_done) else $error("vector fetch did not finish");

  property p_pc_vec;
    s_pc_entry |=> (pc_ff == $past(VEC_RDATA)) && (state_ff == VF_SP);
  endproperty
  a_pc_vec: assert property (p_pc_vec) else $error("program counter not loaded from vector");

  property p_sp_vec;
    s_sp_entry |=> (gpr_ff[STK_REG] == $past(VEC_RDATA)) && running;
  endproperty
  a_sp_vec: assert property (p_sp_vec) else $error("stack pointer not loaded from vector");

  property p_pc_step;
    running && INSTR_ADV && !PC_LOAD |=> pc_ff == $past(pc_ff) + INSTR_BYTES;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("program counter did not step by one instruction");

  property p_sp_push;
    running && SP_PUSH && !SP_POP && !WR_EN |=> gpr_ff[STK_REG] == $past(gpr_ff[STK_REG]) - LONG_BYTES;
  endproperty
  a_sp_push: assert property (p_sp_push) else $error("stack pointer push step wrong");

  property p_stack_align;
    SP_PUSH && (gpr_ff[STK_REG][1:0] != 2'h0) |-> STACK_ADDR_ERR;
  endproperty
  a_stack_align: assert property (p_stack_align) else $error("misaligned stack not flagged");

  property p_addr_err;
    MEM_ADDR_ERR == ((MEM_SIZE == SZ_LONG && MEM_ADDR[1:0] != 2'h0) || (MEM_SIZE == SZ_WORD && MEM_ADDR[0]));
  endproperty
  a_addr_err: assert property (p_addr_err) else $error("address error decision wrong");

  property p_imm_and;
    running && WR_EN && WR_FROM_IMM && IMM_KIND == IMM_ZERO && !bus_wr && !IDX_WR_EN
      |=> gpr_ff[$past(WR_SEL)][31:8] == 24'h00_0000;
  endproperty
  a_imm_and: assert property (p_imm_and) else $error("zero-extended immediate left upper bits set");

  property p_idx_write;
    running && IDX_WR_EN && !sp_take |=> gpr_ff[IDX_REG] == $past(IDX_WR_DATA);
  endproperty
  a_idx_write: assert property (p_idx_write) else $error("index register write lost");

  property p_bus_read;
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == A_VBR |-> AVS_READDATA == vbr_ff;
  endproperty
  a_bus_read: assert property (p_bus_read) else $error("bus read of vector base wrong");
endmodule

// file: verif/vec_table_model.sv
/*
  Vector table partner: answers reset vector reads with the program counter
  entry at offset 0 and the stack pointer entry at offset 4.
  Assumes VEC_RD and VEC_ADDR change only on rising edges of CLOCK.
*/
`timescale 1ns/100ps
module vec_table_model #(
  parameter logic [31:0] PC_ENTRY = 32'h0000_1000,
  parameter logic [31:0] SP_ENTRY = 32'h0000_8000
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // Vector read port
  input wire logic VEC_RD,
  input wire logic [31:0] VEC_ADDR,
  output logic VEC_VALID,
  output logic [31:0] VEC_RDATA
);
  logic [2:0] wait_ff;
  wire [2:0] delay = VEC_ADDR[2] ? 3'h3 : 3'h0;
  // Idle data toggles, so a stale sample never looks right
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      wait_ff <= 3'h0;
      VEC_VALID <= 1'b0;
      VEC_RDATA <= 32'h0000_0000;
    end else if (VEC_RD && !VEC_VALID && wait_ff < delay) begin
      wait_ff <= wait_ff + 3'h1;
      VEC_RDATA <= ~VEC_RDATA;
    end else if (VEC_RD && !VEC_VALID) begin
      wait_ff <= 3'h0;
      VEC_VALID <= 1'b1;
      VEC_RDATA <= VEC_ADDR[2] ? SP_ENTRY : PC_ENTRY;
    end else begin
      VEC_VALID <= 1'b0;
      VEC_RDATA <= ~VEC_RDATA;
    end
  end
endmodule

// file: verif/test_cpu_register_set.sv
/*
  Self-checking bench of the register set: operand widening table, bus,
  stack, program counter, status, multiply and reset sequences.
  Assumes the vector table model and a 100 MHz clock.
*/
`timescale 1ns/100ps
module test_cpu_register_set;
  import cpu_regs_pkg::*;
  localparam logic [31:0] PC_ENTRY = 32'h0000_1000;
  localparam logic [31:0] SP_ENTRY = 32'h0000_8000;
  logic CLOCK = 0, RSTN = 0, AVS_READ = 0, AVS_WRITE = 0, WR_EN = 0, WR_FROM_MEM = 0, WR_FROM_IMM = 0;
  logic IDX_WR_EN = 0, SP_PUSH = 0, SP_POP = 0, STATUS_WR_EN = 0, GBR_WR_EN = 0, VBR_WR_EN = 0, PR_WR_EN = 0;
  logic T_WR_EN = 0, T_VALUE = 0, INSTR_ADV = 0, PC_LOAD = 0, PCREL_LONG = 0, MUL_EN = 0, MAC_EN = 0;
  logic [4:0] AVS_ADDRESS = 0;
  logic [3:0] AVS_BYTEENABLE = 4'hf, RD_A_SEL = 0, RD_B_SEL = 0, WR_SEL = 0, INTERRUPT_MASK_FIELD;
  logic [7:0] IMM_FIELD = 0, GBR_DISP = 0, PCREL_DISP = 0;
  logic [15:0] MUL_A = 0, MUL_B = 0;
  logic [31:0] AVS_WRITEDATA = 0, WR_DATA = 0, IDX_WR_DATA = 0, CTRL_WR_DATA = 0, PC_TARGET = 0, MEM_ADDR = 0;
  logic [31:0] AVS_READDATA, VEC_ADDR, VEC_RDATA, RD_A_DATA, RD_B_DATA, INDEX_GENERAL_REG, STACK_POINTER;
  logic [31:0] STACK_ADDR, STATUS_WORD, GLOBAL_BASE_REG, VECTOR_BASE_REG, RETURN_LINK_REG, PERIPH_ADDR;
  logic [31:0] PROGRAM_COUNTER, PCREL_ADDR, MULTIPLY_ACC_HIGH, MULTIPLY_ACC_LOW, q;
  logic AVS_WAITREQUEST, VEC_RD, VEC_VALID, CORE_READY, STACK_ADDR_ERR, T_FLAG, MEM_ADDR_ERR;
  size_e WR_SIZE = SZ_LONG, MEM_SIZE = SZ_BYTE;
  imm_e IMM_KIND = IMM_SIGNED;
  int mismatches = 0, tests_run = 0;
  typedef struct {logic [3:0] sel; logic mem; logic imm; size_e sz; imm_e kind; logic [31:0] d;
    logic [7:0] i8; logic [1:0] a; logic err; logic [31:0] exp;} row_s;
  // Widening source, alignment offset, expected register and address error
  row_s rows [8] = '{
    '{4'h1, 1'b1, 1'b0, SZ_BYTE, IMM_SIGNED, 32'h0000_0080, 8'h00, 2'h3, 1'b0, 32'hffff_ff80},
    '{4'h2, 1'b1, 1'b0, SZ_WORD, IMM_SIGNED, 32'h0000_8001, 8'h00, 2'h1, 1'b1, 32'hffff_8001},
    '{4'h3, 1'b1, 1'b0, SZ_WORD, IMM_SIGNED, 32'hffff_1234, 8'h00, 2'h2, 1'b0, 32'h0000_1234},
    '{4'h4, 1'b1, 1'b0, SZ_LONG, IMM_SIGNED, 32'h8000_0000, 8'h00, 2'h2, 1'b1, 32'h8000_0000},
    '{4'h5, 1'b0, 1'b1, SZ_LONG, IMM_SIGNED, 32'h0000_0000, 8'h80, 2'h0, 1'b0, 32'hffff_ff80},
    '{4'h6, 1'b0, 1'b1, SZ_BYTE, IMM_ZERO, 32'h0000_0000, 8'h80, 2'h1, 1'b0, 32'h0000_0080},
    '{4'h7, 1'b0, 1'b0, SZ_LONG, IMM_SIGNED, 32'hdead_beef, 8'h00, 2'h0, 1'b0, 32'hdead_beef},
    '{4'he, 1'b0, 1'b1, SZ_WORD, IMM_SIGNED, 32'h0000_0000, 8'h7f, 2'h3, 1'b1, 32'h0000_007f}};

  cpu_register_set i_dut (.CLOCK, .RSTN, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE,
    .AVS_READDATA, .AVS_WAITREQUEST, .VEC_RD, .VEC_ADDR, .VEC_VALID, .VEC_RDATA, .CORE_READY, .RD_A_SEL,
    .RD_A_DATA, .RD_B_SEL, .RD_B_DATA, .INDEX_GENERAL_REG, .STACK_POINTER, .WR_EN, .WR_SEL, .WR_FROM_MEM,
    .WR_FROM_IMM, .WR_DATA, .WR_SIZE, .IMM_FIELD, .IMM_KIND, .IDX_WR_EN, .IDX_WR_DATA, .SP_PUSH, .SP_POP,
    .STACK_ADDR, .STACK_ADDR_ERR, .STATUS_WR_EN, .GBR_WR_EN, .VBR_WR_EN, .PR_WR_EN, .CTRL_WR_DATA, .T_WR_EN,
    .T_VALUE, .STATUS_WORD, .T_FLAG, .INTERRUPT_MASK_FIELD, .GLOBAL_BASE_REG, .VECTOR_BASE_REG,
    .RETURN_LINK_REG, .PERIPH_ADDR, .GBR_DISP, .INSTR_ADV, .PC_LOAD, .PC_TARGET, .PROGRAM_COUNTER,
    .PCREL_DISP, .PCREL_LONG, .PCREL_ADDR, .MUL_EN, .MAC_EN, .MUL_A, .MUL_B, .MULTIPLY_ACC_HIGH,
    .MULTIPLY_ACC_LOW, .MEM_ADDR, .MEM_SIZE, .MEM_ADDR_ERR);
  vec_table_model #(.PC_ENTRY(PC_ENTRY), .SP_ENTRY(SP_ENTRY)) i_vec (.CLOCK, .RSTN, .VEC_RD, .VEC_ADDR,
    .VEC_VALID, .VEC_RDATA);

  always #5 CLOCK = ~CLOCK;

  task automatic report_and_stop;
    $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low at a rising edge; data taken and released there
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do begin
      @(posedge CLOCK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 200);
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (AVS_WAITREQUEST !== 1'b0) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  // Reset-time values and the vector fetch; the read stalls until loaded
  task automatic reset_test(input string s);
    @(negedge CLOCK);
    chk(STATUS_WORD, 32'h0000_00f0);
    chk({28'h0, INTERRUPT_MASK_FIELD}, 32'h0000_000f);
    chk(VECTOR_BASE_REG, 32'h0000_0000);
    chk({31'h0, CORE_READY}, 32'h0000_0000);
    @(posedge CLOCK);
    RSTN <= 1'b1;
    bus(1'b0, A_PC, 32'h0, q);
    chk(q, PC_ENTRY);
    chk(STACK_POINTER, SP_ENTRY);
    chk({30'h0, VEC_RD, CORE_READY}, 32'h0000_0001);
    $display("Test %s complete", s);
  endtask

  initial begin
    repeat (6) @(posedge CLOCK);
    reset_test("reset");
    foreach (rows[k]) begin
      @(posedge CLOCK);
      WR_EN <= 1'b1;
      WR_SEL <= rows[k].sel;
      WR_FROM_MEM <= rows[k].mem;
      WR_FROM_IMM <= rows[k].imm;
      WR_SIZE <= rows[k].sz;
      MEM_SIZE <= rows[k].sz;
      IMM_KIND <= rows[k].kind;
      WR_DATA <= rows[k].d;
      IMM_FIELD <= rows[k].i8;
      MEM_ADDR <= {30'h0, rows[k].a};
      RD_A_SEL <= rows[k].sel;
      RD_B_SEL <= rows[k].sel;
      @(negedge CLOCK);
      chk({31'h0, MEM_ADDR_ERR}, {31'h0, rows[k].err});
      @(posedge CLOCK);
      WR_EN <= 1'b0;
      @(negedge CLOCK);
      chk(RD_A_DATA, rows[k].exp);
      chk(RD_B_DATA, rows[k].exp);
    end
    $display("Test widening complete");
    bus(1'b1, A_GBR, 32'h0000_2000, q);
    AVS_BYTEENABLE <= 4'h1;
    bus(1'b1, A_GBR, 32'hffff_ffff, q);
    AVS_BYTEENABLE <= 4'hf;
    GBR_DISP <= 8'h90;
    bus(1'b0, 5'h1f, 32'h0, q);
    chk(q, 32'h0000_0000);
    chk(GLOBAL_BASE_REG, 32'h0000_20ff);
    chk(PERIPH_ADDR, 32'h0000_218f);
    IDX_WR_EN <= 1'b1;
    IDX_WR_DATA <= 32'h0000_00aa;
    @(posedge CLOCK);
    IDX_WR_EN <= 1'b0;
    @(negedge CLOCK);
    chk(INDEX_GENERAL_REG, 32'h0000_00aa);
    $display("Test bus complete");
    @(posedge CLOCK);
    SP_PUSH <= 1'b1;
    @(negedge CLOCK);
    chk(STACK_ADDR, SP_ENTRY - 32'h4);
    chk({31'h0, STACK_ADDR_ERR}, 32'h0);
    @(posedge CLOCK);
    SP_PUSH <= 1'b0;
    SP_POP <= 1'b1;
    @(negedge CLOCK);
    chk(STACK_ADDR, SP_ENTRY - 32'h4);
    @(posedge CLOCK);
    SP_POP <= 1'b0;
    @(negedge CLOCK);
    chk(STACK_POINTER, SP_ENTRY);
    bus(1'b1, 5'h0f, 32'h0000_8002, q);
    SP_PUSH <= 1'b1;
    @(negedge CLOCK);
    chk({31'h0, STACK_ADDR_ERR}, 32'h1);
    @(posedge CLOCK);
    SP_PUSH <= 1'b0;
    PC_LOAD <= 1'b1;
    INSTR_ADV <= 1'b1;
    PC_TARGET <= 32'h0000_0100;
    @(posedge CLOCK);
    PC_LOAD <= 1'b0;
    repeat (2) @(posedge CLOCK);
    INSTR_ADV <= 1'b0;
    PCREL_LONG <= 1'b1;
    PCREL_DISP <= 8'h01;
    @(negedge CLOCK);
    chk(PROGRAM_COUNTER, 32'h0000_0104);
    chk(PCREL_ADDR, 32'h0000_010c);
    @(posedge CLOCK);
    PCREL_LONG <= 1'b0;
    PCREL_DISP <= 8'h03;
    @(negedge CLOCK);
    chk(PCREL_ADDR, 32'h0000_010e);
    $display("Test stack and counter complete");
    bus(1'b1, A_MULTIPLY_ACC_HIGH, 32'h0000_01ff, q);
    bus(1'b1, A_MULTIPLY_ACC_LOW, 32'hffff_ffff, q);
    MAC_EN <= 1'b1;
    MUL_A <= 16'h0001;
    MUL_B <= 16'h0001;
    @(posedge CLOCK);
    MAC_EN <= 1'b0;
    MUL_EN <= 1'b1;
    MUL_A <= 16'hfffe;
    MUL_B <= 16'h0003;
    @(negedge CLOCK);
    chk(MULTIPLY_ACC_HIGH, 32'hffff_fe00);
    chk(MULTIPLY_ACC_LOW, 32'h0000_0000);
    @(posedge CLOCK);
    MUL_EN <= 1'b0;
    STATUS_WR_EN <= 1'b1;
    PR_WR_EN <= 1'b1;
    VBR_WR_EN <= 1'b1;
    GBR_WR_EN <= 1'b1;
    CTRL_WR_DATA <= 32'hffff_ffff;
    @(negedge CLOCK);
    chk(MULTIPLY_ACC_LOW, 32'hffff_fffa);
    @(posedge CLOCK);
    {STATUS_WR_EN, PR_WR_EN, VBR_WR_EN, GBR_WR_EN} <= 4'h0;
    T_WR_EN <= 1'b1;
    @(negedge CLOCK);
    chk(STATUS_WORD, 32'h0000_03f3);
    chk(RETURN_LINK_REG, 32'hffff_ffff);
    chk(VECTOR_BASE_REG, 32'hffff_ffff);
    @(posedge CLOCK);
    T_WR_EN <= 1'b0;
    @(negedge CLOCK);
    chk(STATUS_WORD, 32'h0000_03f2);
    chk({31'h0, T_FLAG}, 32'h0);
    bus(1'b0, A_VBR, 32'h0, q);
    chk(q, 32'hffff_ffff);
    $display("Test control complete");
    // Second reset in mid-run must clear the vector base and refetch
    @(posedge CLOCK);
    RSTN <= 1'b0;
    reset_test("second reset");
    report_and_stop();
  end
endmodule
